// ---- include/etf_params.svh ----
// Constants of the event force and flag block: offsets, field
// positions and reset values.
// Assumes inclusion by bare name from the package and the modules.
`ifndef ETF_PARAMS_SVH
`define ETF_PARAMS_SVH

// Register offsets on the plain register port
`define ETF_OFS_SEL 4'h0
`define ETF_OFS_FLG 4'h1
`define ETF_OFS_CLR 4'h2
`define ETF_OFS_FRC 4'h3
`define ETF_OFS_ISTAT 4'h4
`define ETF_OFS_IMASK 4'h5

// Field positions shared by select, flag, clear, force and status
`define ETF_BIT_INT 0
`define ETF_BIT_CONVERSION_START_A 2
`define ETF_BIT_CONVERSION_START_B 3

// Widths and reset values
`define ETF_ADDR_W 4
`define ETF_DATA_W 16
`define ETF_RST_REG 16'h0000
`define ETF_RST_EVT 4'h0

`endif

// ---- include/etf_pkg.sv ----
// Types of the event force and flag block.
// Assumes the params header is on the include path.
`include "etf_params.svh"

package etf_pkg;

  // Event bits in register layout: bit 3, bit 2, bit 1 (unused), bit 0
  typedef struct packed {
    logic conversion_start_b;
    logic conversion_start_a;
    logic rsv;
    logic intr;
  } etf_evt_t;

  // One request on the register port
  typedef struct packed {
    logic [`ETF_ADDR_W-1:0] addr;
    logic [`ETF_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } etf_req_t;

  // Interrupt gate states, one-hot
  typedef enum logic [2:0] {
    ETF_IDLE = 3'b001,
    ETF_FLAG = 3'b010,
    ETF_PEND = 3'b100
  } etf_gate_st_t;

endpackage : etf_pkg

// ---- rtl/etf_int_gate.sv ----
// Interrupt gate: latched interrupt flag, one pending slot, pulse out.
// Assumes request, force and clear are one-cycle pulses on CORE_CLK.
`timescale 1ns/100ps
`default_nettype none

module etf_int_gate
  import etf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Enabled interrupt event, raw force, flag clear
  input wire logic req,
  input wire logic frc,
  input wire logic clr,
  // Flag, pending slot and interrupt pulse
  output logic flag,
  output logic pend,
  output logic fire
);

  typedef struct packed {
    etf_gate_st_t st;
    logic fire;
  } etf_gate_t;

  etf_gate_t s_q;
  etf_gate_t s_d;

  // Next state: flag blocks pulses, one event may wait behind it
  always_comb begin
    s_d = s_q;
    s_d.fire = 1'b0;
    case (s_q.st)
      ETF_IDLE: begin
        if (req) begin
          s_d.st = ETF_FLAG;
          s_d.fire = 1'b1;
        end else if (frc) begin
          s_d.st = ETF_FLAG;
        end
      end
      ETF_FLAG: begin
        if (clr) begin
          if (req) begin
            s_d.fire = 1'b1; // Event beats the clear
            s_d.st = ETF_FLAG;
          end else if (frc) begin
            s_d.st = ETF_FLAG;
          end else begin
            s_d.st = ETF_IDLE;
          end
        end else if (req) begin
          s_d.st = ETF_PEND;
        end
      end
      ETF_PEND: begin
        if (clr) begin
          s_d.fire = 1'b1;
          s_d.st = req ? ETF_PEND : ETF_FLAG;
        end
      end
      default: s_d.st = ETF_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: ETF_IDLE, fire: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign flag = (s_q.st != ETF_IDLE);
  assign pend = (s_q.st == ETF_PEND);
  assign fire = s_q.fire;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_no_fire_while_flag;
    flag && !clr |=> !fire;
  endproperty
  a_no_fire_while_flag: assert property (p_no_fire_while_flag)
    else $error("Interrupt pulse while flag held");

  property p_pend_after_clear;
    pend && clr |=> fire ##1 flag;
  endproperty
  a_pend_after_clear: assert property (p_pend_after_clear)
    else $error("Pending interrupt not issued after clear");

  property p_pend_waits;
    pend && !clr |=> !fire && pend;
  endproperty
  a_pend_waits: assert property (p_pend_waits)
    else $error("Pending interrupt left before clear");

endmodule : etf_int_gate

`default_nettype wire

// ---- rtl/etf_core.sv ----
// Event force and flag logic: select, flag, clear and force registers,
// conversion-start pulses, interrupt pulse and a level interrupt line.
// Assumes upstream event pulses and the register port are synchronous
// to CORE_CLK, and strobes are single cycles, never both at once.
`timescale 1ns/100ps
`default_nettype none
`include "etf_params.svh"

// How it works
// - Forced B pulses only when B enabled
// - Forced A pulses only when A enabled
// - Forced interrupt fires only when enabled
// - Any force sets its flag always
// - Force zeros ignored, force reads zero
// - Clear ones clear flags, read zero
// - Set interrupt flag blocks further pulses
// - One interrupt held pending until clear
// - Conversion pulses continue despite set flags
module etf_core
  import etf_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Register port
  input wire etf_req_t REG_REQ,
  output logic [`ETF_DATA_W-1:0] REG_RDATA,
  // Natural events from the event selection stage
  input wire etf_evt_t EVT_IN,
  // Conversion-start and module interrupt pulses
  output logic CONV_START_A,
  output logic CONV_START_B,
  output logic PWM_IRQ,
  // Level interrupt from sticky status and mask
  output logic IRQ
);

  typedef struct packed {
    etf_evt_t sel;
    logic conversion_start_a_flg;
    logic conversion_start_b_flg;
    logic conversion_start_a_out;
    logic conversion_start_b_out;
    etf_evt_t istat;
    etf_evt_t imask;
    logic irq;
    logic [`ETF_DATA_W-1:0] rdata;
  } etf_core_t;

  etf_core_t s_q;
  etf_core_t s_d;

  // Keeps only the defined event bits of a data word
  function automatic etf_evt_t evt_of(input logic [`ETF_DATA_W-1:0] w);
    etf_evt_t e;
    e.conversion_start_b = w[`ETF_BIT_CONVERSION_START_B];
    e.conversion_start_a = w[`ETF_BIT_CONVERSION_START_A];
    e.rsv = 1'b0;
    e.intr = w[`ETF_BIT_INT];
    return e;
  endfunction : evt_of

  // Widens an event set to a data word, unused bits zero
  function automatic logic [`ETF_DATA_W-1:0] word_of(input etf_evt_t e);
    logic [`ETF_DATA_W-1:0] w;
    w = `ETF_RST_REG;
    w[`ETF_BIT_CONVERSION_START_B] = e.conversion_start_b;
    w[`ETF_BIT_CONVERSION_START_A] = e.conversion_start_a;
    w[`ETF_BIT_INT] = e.intr;
    return w;
  endfunction : word_of

  // Address hits for a write
  logic wr_sel;
  logic wr_clr;
  logic wr_frc;
  logic wr_istat;
  logic wr_imask;
  etf_evt_t wevt;
  etf_evt_t frc;
  etf_evt_t clr;
  etf_evt_t occ;
  etf_evt_t flags;
  logic int_flag;
  logic int_pend;
  logic int_fire;

  // Write decode; in clear, force and status writes ones act, zeros do nothing
  always_comb begin
    wevt = evt_of(REG_REQ.wdata);
    wr_sel = 1'b0;
    wr_clr = 1'b0;
    wr_frc = 1'b0;
    wr_istat = 1'b0;
    wr_imask = 1'b0;
    if (!REG_REQ.wr) begin
      wr_sel = 1'b0;
    end else if (REG_REQ.addr == `ETF_OFS_SEL) begin
      wr_sel = 1'b1;
    end else if (REG_REQ.addr == `ETF_OFS_CLR) begin
      wr_clr = 1'b1;
    end else if (REG_REQ.addr == `ETF_OFS_FRC) begin
      wr_frc = 1'b1;
    end else if (REG_REQ.addr == `ETF_OFS_ISTAT) begin
      wr_istat = 1'b1;
    end else if (REG_REQ.addr == `ETF_OFS_IMASK) begin
      wr_imask = 1'b1;
    end
    frc = wr_frc ? wevt : etf_evt_t'(`ETF_RST_EVT);
    clr = wr_clr ? wevt : etf_evt_t'(`ETF_RST_EVT);
  end

  // Event occurrence: natural pulse or force, same path and timing
  assign occ.conversion_start_b = EVT_IN.conversion_start_b | frc.conversion_start_b;
  assign occ.conversion_start_a = EVT_IN.conversion_start_a | frc.conversion_start_a;
  assign occ.rsv = 1'b0;
  assign occ.intr = EVT_IN.intr | frc.intr;

  // Interrupt flag, pending slot and pulse
  etf_int_gate u_gate (
    .clk (CORE_CLK),
    .rst_n (RESET_N),
    .req (occ.intr & s_q.sel.intr),
    .frc (frc.intr),
    .clr (clr.intr),
    .flag (int_flag),
    .pend (int_pend),
    .fire (int_fire)
  );

  // Flag register view as software reads it
  always_comb begin
    flags.conversion_start_b = s_q.conversion_start_b_flg;
    flags.conversion_start_a = s_q.conversion_start_a_flg;
    flags.rsv = 1'b0;
    flags.intr = int_flag;
  end

  // Next state of the register file and outputs
  always_comb begin
    s_d = s_q;
    if (wr_sel) begin
      s_d.sel = wevt;
    end
    if (wr_imask) begin
      s_d.imask = wevt;
    end
    // Pulses go out the cycle after the event, flags do not gate them,
    s_d.conversion_start_a_out = occ.conversion_start_a & s_q.sel.conversion_start_a;
    s_d.conversion_start_b_out = occ.conversion_start_b & s_q.sel.conversion_start_b;
    // A flag sets on a pulse or on any force; set beats clear
    s_d.conversion_start_a_flg = (s_q.conversion_start_a_flg & ~clr.conversion_start_a) | s_d.conversion_start_a_out
      | frc.conversion_start_a;
    s_d.conversion_start_b_flg = (s_q.conversion_start_b_flg & ~clr.conversion_start_b) | s_d.conversion_start_b_out
      | frc.conversion_start_b;
    // Sticky status, write one to clear, a new event wins
    s_d.istat.conversion_start_b = (s_q.istat.conversion_start_b & ~(wr_istat & wevt.conversion_start_b))
      | s_d.conversion_start_b_out;
    s_d.istat.conversion_start_a = (s_q.istat.conversion_start_a & ~(wr_istat & wevt.conversion_start_a))
      | s_d.conversion_start_a_out;
    s_d.istat.rsv = 1'b0;
    s_d.istat.intr = (s_q.istat.intr & ~(wr_istat & wevt.intr))
      | int_fire;
    s_d.irq = |(s_d.istat & s_d.imask);
    // Read data valid only in the cycle after the read strobe
    s_d.rdata = `ETF_RST_REG;
    if (!REG_REQ.rd) begin
      s_d.rdata = `ETF_RST_REG;
    end else if (REG_REQ.addr == `ETF_OFS_SEL) begin
      s_d.rdata = word_of(s_q.sel);
    end else if (REG_REQ.addr == `ETF_OFS_FLG) begin
      s_d.rdata = word_of(flags);
    end else if (REG_REQ.addr == `ETF_OFS_ISTAT) begin
      s_d.rdata = word_of(s_q.istat);
    end else if (REG_REQ.addr == `ETF_OFS_IMASK) begin
      s_d.rdata = word_of(s_q.imask);
    end else begin
      s_d.rdata = `ETF_RST_REG; // Clear, force, unmapped read zero
    end
  end

  // State register
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q <= '{sel: `ETF_RST_EVT, conversion_start_a_flg: 1'b0, conversion_start_b_flg: 1'b0,
        conversion_start_a_out: 1'b0, conversion_start_b_out: 1'b0, istat: `ETF_RST_EVT,
        imask: `ETF_RST_EVT, irq: 1'b0, rdata: `ETF_RST_REG};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign REG_RDATA = s_q.rdata;
  assign CONV_START_A = s_q.conversion_start_a_out;
  assign CONV_START_B = s_q.conversion_start_b_out;
  assign PWM_IRQ = int_fire;
  assign IRQ = s_q.irq;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  property p_frc_b_enabled;
    wr_frc && wevt.conversion_start_b && s_q.sel.conversion_start_b |=> CONV_START_B;
  endproperty
  a_frc_b_enabled: assert property (p_frc_b_enabled)
    else $error("Forced B pulse missing");

  property p_frc_a_disabled;
    wr_frc && wevt.conversion_start_a && !s_q.sel.conversion_start_a && !EVT_IN.conversion_start_a
      |=> !CONV_START_A && s_q.conversion_start_a_flg;
  endproperty
  a_frc_a_disabled: assert property (p_frc_a_disabled)
    else $error("Forced A pulsed while disabled or flag not set");

  property p_frc_int;
    wr_frc && wevt.intr && s_q.sel.intr && !int_flag |=> PWM_IRQ;
  endproperty
  a_frc_int: assert property (p_frc_int)
    else $error("Forced interrupt not issued");

  property p_frc_int_disabled;
    wr_frc && wevt.intr && !s_q.sel.intr && !EVT_IN.intr && !int_flag
      |=> !PWM_IRQ ##0 int_flag;
  endproperty
  a_frc_int_disabled: assert property (p_frc_int_disabled)
    else $error("Disabled forced interrupt misbehaved");

  property p_frc_reads_zero;
    REG_REQ.rd && (REG_REQ.addr == `ETF_OFS_FRC
      || REG_REQ.addr == `ETF_OFS_CLR) |=> REG_RDATA == `ETF_RST_REG;
  endproperty
  a_frc_reads_zero: assert property (p_frc_reads_zero)
    else $error("Force or clear register read nonzero");

  property p_clr_a;
    wr_clr && wevt.conversion_start_a && !occ.conversion_start_a |=> !s_q.conversion_start_a_flg;
  endproperty
  a_clr_a: assert property (p_clr_a)
    else $error("Clear did not drop flag A");

  property p_zero_clr_keeps;
    s_q.conversion_start_b_flg && wr_clr && !wevt.conversion_start_b |=> s_q.conversion_start_b_flg;
  endproperty
  a_zero_clr_keeps: assert property (p_zero_clr_keeps)
    else $error("Zero written to clear affected flag B");

  property p_pulse_with_flag;
    s_q.conversion_start_a_flg && EVT_IN.conversion_start_a && s_q.sel.conversion_start_a |=> CONV_START_A;
  endproperty
  a_pulse_with_flag: assert property (p_pulse_with_flag)
    else $error("Conversion pulse suppressed by set flag");

  property p_natural_b;
    EVT_IN.conversion_start_b && s_q.sel.conversion_start_b |=> CONV_START_B;
  endproperty
  a_natural_b: assert property (p_natural_b)
    else $error("Natural B pulse not in next cycle");

  property p_b_only_qualified;
    !(occ.conversion_start_b && s_q.sel.conversion_start_b) |=> !CONV_START_B;
  endproperty
  a_b_only_qualified: assert property (p_b_only_qualified)
    else $error("B pulse without an enabled event");

endmodule : etf_core

`default_nettype wire

// ---- testbench/etf_far_model.sv ----
// Far side model: expansion interrupt flag and conversion-start inputs.
// Assumes one-cycle high pulses synchronous to the block clock.
`timescale 1ns/100ps
`default_nettype none

module etf_far_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pulses from the block, software clear of the expansion flag
  input wire logic conversion_start_a,
  input wire logic conversion_start_b,
  input wire logic irq,
  input wire logic flag_clr,
  // Pulse counts and the latched expansion flag
  output logic [7:0] cnt_a_q,
  output logic [7:0] cnt_b_q,
  output logic [7:0] cnt_i_q,
  output logic xflag_q
);
  // Count every pulse; latch the flag until software clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_a_q <= 8'h00;
      cnt_b_q <= 8'h00;
      cnt_i_q <= 8'h00;
      xflag_q <= 1'b0;
    end else begin
      cnt_a_q <= cnt_a_q + {7'h00, conversion_start_a};
      cnt_b_q <= cnt_b_q + {7'h00, conversion_start_b};
      cnt_i_q <= cnt_i_q + {7'h00, irq};
      xflag_q <= irq | (xflag_q & !flag_clr);
    end
  end
endmodule : etf_far_model

`default_nettype wire

// ---- testbench/event_trigger_force_tb.sv ----
// Testbench of the event force and flag block.
// Assumes the package, params header and far side model are compiled.
`timescale 1ns/100ps
`default_nettype none
`include "etf_params.svh"

module event_trigger_force_tb;
  import etf_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  etf_req_t req = '0;
  etf_evt_t evt = '0;
  logic fclr = 1'b0;
  logic [15:0] rdata;
  logic ca, cb, pi, irq, xf;
  logic [7:0] na, nb, ni;
  int num_errors = 0;
  int n_checks = 0;

  // Clock, 10 ns period
  always #5 core_clk = ~core_clk;

  etf_core uut (.CORE_CLK(core_clk), .RESET_N(reset_n), .REG_REQ(req),
    .REG_RDATA(rdata), .EVT_IN(evt), .CONV_START_A(ca),
    .CONV_START_B(cb), .PWM_IRQ(pi), .IRQ(irq));

  etf_far_model far (.clk(core_clk), .rst_n(reset_n), .conversion_start_a(ca),
    .conversion_start_b(cb), .irq(pi), .flag_clr(fclr), .cnt_a_q(na), .cnt_b_q(nb),
    .cnt_i_q(ni), .xflag_q(xf));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One write cycle; returns just after the edge that takes it
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req <= '0;
    #1;
  endtask : wr

  // One read cycle, data compared in the cycle after it
  task rchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req <= '0;
    #1;
    chk(rdata, exp);
  endtask : rchk

  function automatic logic [15:0] outs();
    return {13'h0000, ca, cb, pi};
  endfunction : outs

  task t_reset();
    for (int a = 0; a < 7; a++) begin
      rchk(a[3:0], 16'h0000);
    end
    $display("test reset done");
  endtask : t_reset

  task t_frc_off();
    wr(`ETF_OFS_SEL, 16'h0000);
    wr(`ETF_OFS_FRC, 16'h0000);
    rchk(`ETF_OFS_FLG, 16'h0000);
    wr(`ETF_OFS_FRC, 16'h000F);
    chk(outs(), 16'h0000);
    rchk(`ETF_OFS_FLG, 16'h000D);
    rchk(`ETF_OFS_FRC, 16'h0000);
    chk({ni, na | nb}, 16'h0000);
    wr(`ETF_OFS_CLR, 16'h0000);
    rchk(`ETF_OFS_FLG, 16'h000D);
    wr(`ETF_OFS_CLR, 16'h0004);
    rchk(`ETF_OFS_FLG, 16'h0009);
    rchk(`ETF_OFS_CLR, 16'h0000);
    wr(`ETF_OFS_CLR, 16'h0009);
    rchk(`ETF_OFS_FLG, 16'h0000);
    $display("test force disabled done");
  endtask : t_frc_off

  task t_soc();
    wr(`ETF_OFS_SEL, 16'h000C);
    wr(`ETF_OFS_FRC, 16'h0004);
    chk(outs(), 16'h0004);
    @(posedge core_clk);
    #1;
    chk(outs(), 16'h0000);
    wr(`ETF_OFS_FRC, 16'h0008);
    chk(outs(), 16'h0002);
    wr(`ETF_OFS_FRC, 16'h0008);
    chk(outs(), 16'h0002);
    @(posedge core_clk);
    evt <= '{conversion_start_b: 1'b1, conversion_start_a: 1'b1, rsv: 1'b0, intr: 1'b0};
    @(posedge core_clk);
    evt <= '0;
    #1;
    chk(outs(), 16'h0006);
    // Far side counts a pulse at the edge that ends it
    @(posedge core_clk);
    #1;
    chk({na, nb}, 16'h0203);
    rchk(`ETF_OFS_ISTAT, 16'h000C);
    wr(`ETF_OFS_ISTAT, 16'h000C);
    rchk(`ETF_OFS_FLG, 16'h000C);
    wr(`ETF_OFS_CLR, 16'h000C);
    $display("test conversion starts done");
  endtask : t_soc

  task t_int();
    wr(`ETF_OFS_SEL, 16'h0001);
    wr(`ETF_OFS_FRC, 16'h0001);
    chk(outs(), 16'h0001);
    wr(`ETF_OFS_FRC, 16'h0001);
    chk(outs(), 16'h0000);
    wr(`ETF_OFS_FRC, 16'h0001);
    wr(`ETF_OFS_CLR, 16'h0001);
    repeat (2) @(posedge core_clk);
    #1;
    chk({8'h00, ni}, 16'h0002);
    rchk(`ETF_OFS_FLG, 16'h0001);
    wr(`ETF_OFS_CLR, 16'h0001);
    repeat (2) @(posedge core_clk);
    #1;
    chk({8'h00, ni}, 16'h0002);
    rchk(`ETF_OFS_FLG, 16'h0000);
    wr(`ETF_OFS_FRC, 16'h0001);
    chk(outs(), 16'h0001);
    chk({15'h0000, xf}, 16'h0001);
    $display("test interrupt gate done");
  endtask : t_int

  task t_irq();
    rchk(`ETF_OFS_ISTAT, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    wr(`ETF_OFS_IMASK, 16'h0001);
    rchk(`ETF_OFS_IMASK, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    wr(`ETF_OFS_ISTAT, 16'h0000);
    repeat (2) @(posedge core_clk);
    #1;
    chk({15'h0000, irq}, 16'h0001);
    wr(`ETF_OFS_ISTAT, 16'h0001);
    repeat (2) @(posedge core_clk);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    rchk(`ETF_OFS_ISTAT, 16'h0000);
    $display("test level interrupt done");
  endtask : t_irq

  task conclude();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // Main sequence: reset, software bring-up in order, then the tests
  initial begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    wr(`ETF_OFS_IMASK, 16'h0000);
    wr(`ETF_OFS_SEL, 16'h0000);
    wr(`ETF_OFS_CLR, 16'h000D);
    wr(`ETF_OFS_ISTAT, 16'h000D);
    @(posedge core_clk);
    fclr <= 1'b1;
    @(posedge core_clk);
    fclr <= 1'b0;
    t_frc_off();
    t_soc();
    t_int();
    t_irq();
    conclude();
  end

  // Watchdog well beyond the roughly 110 cycles of the tests
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
endmodule : event_trigger_force_tb

`default_nettype wire
